// File: src/psbs_pkg.sv
// ============================================================
// psbs_pkg: constants and types for program space bank select
// assumes: 8-bit core with 16-bit program addresses, 128 kB flash
// ============================================================
package psbs_pkg;

    // ========================================================
    // address widths
    localparam int PSBS_LADDR_W = 16;
    localparam int PSBS_PADDR_W = 17;
    localparam int PSBS_BANK_W = 2;
    localparam int PSBS_OFS_W = 15;
    localparam int PSBS_SFR_W = 8;

    // ========================================================
    // bank select register
    localparam logic [7:0] PSBS_SFR_ADDR = 8'h84;
    localparam logic [7:0] PSBS_RESET_VAL = 8'h11;
    localparam int PSBS_FETCH_LSB = 0;
    localparam int PSBS_CONST_LSB = 4;
    localparam logic [1:0] PSBS_BANK0 = 2'h0;

    // ========================================================
    // window and data memory sizes
    localparam int PSBS_UPPER_BIT = 15;
    localparam int PSBS_IRAM_W = 8;
    localparam int PSBS_XRAM_W = 13;
    localparam logic [12:0] PSBS_XRAM_MASK_BIG = 13'h1FFF;
    localparam logic [12:0] PSBS_XRAM_MASK_SMALL = 13'h0FFF;

    typedef logic [PSBS_BANK_W-1:0] psbs_bank_t;
    typedef logic [PSBS_LADDR_W-1:0] psbs_laddr_t;
    typedef logic [PSBS_PADDR_W-1:0] psbs_paddr_t;

    // ========================================================
    // bank seen by a logical address: lower half always bank 0
    function automatic psbs_bank_t psbs_eff_bank(input psbs_laddr_t a, input psbs_bank_t b);
        return a[PSBS_UPPER_BIT] ? b : PSBS_BANK0;
    endfunction

endpackage

// File: src/psbs_map_if.sv
// ============================================================
// psbs_map_if: carries logical addresses and banks to the mapper
// assumes: mapper is purely combinational
// ============================================================
`timescale 1ns/100ps
`default_nettype none
interface psbs_map_if;
    import psbs_pkg::*;
    psbs_laddr_t fetch_laddr;
    psbs_laddr_t const_laddr;
    psbs_bank_t fetch_bank;
    psbs_bank_t const_bank;
    psbs_paddr_t fetch_paddr;
    psbs_paddr_t const_paddr;
    modport mapper (
        input fetch_laddr, const_laddr, fetch_bank, const_bank,
        output fetch_paddr, const_paddr
    );
    modport user (
        output fetch_laddr, const_laddr, fetch_bank, const_bank,
        input fetch_paddr, const_paddr
    );
endinterface
`default_nettype wire

// File: src/psbs_mapper.sv
// ============================================================
// psbs_mapper: logical to physical flash address translation
// assumes: banks come from the bank select register of the top
// ============================================================
`timescale 1ns/100ps
`default_nettype none
module psbs_mapper (
    // translation carrier
    psbs_map_if.mapper m
);
    import psbs_pkg::*;

    // join bank number with the low 15 address bits
    function automatic psbs_paddr_t psbs_phys(input psbs_laddr_t a, input psbs_bank_t b);
        return {psbs_eff_bank(a, b), a[PSBS_OFS_W-1:0]};
    endfunction

    // instruction fetch and constant paths use separate banks
    assign m.fetch_paddr = psbs_phys(m.fetch_laddr, m.fetch_bank);
    assign m.const_paddr = psbs_phys(m.const_laddr, m.const_bank);
endmodule // psbs_mapper
`default_nettype wire

// File: src/psbs_top.sv
// ============================================================
// psbs_top: program space bank select and memory steering
// assumes: core drives requests synchronously on clock; one request
// of each kind per cycle; answers are registered one cycle later
// ============================================================
`timescale 1ns/100ps
`default_nettype none

// Operation
// - program addresses 0x0000 to 0x7FFF always map to flash bank 0.
// - fetches to 0x8000 to 0xFFFF use the bank in fetch field bits 1:0.
// - the fetch field is a plain binary bank number 0 to 3.
// - constant reads and flash writes in the upper window use the constant field bits 5:4.
// - the constant field is a plain binary bank number 0 to 3.
// - the fetch field only changes when the writing code runs from bank 0.
// - bits 7:6 and 3:2 read as zero and software writes them as zero.
// - the bank select register resets to 0x11.
// - constant-table reads always go to flash, never to data memory.
// - data-move reads go to XRAM; writes go to XRAM when flash writing is disabled, else to flash unless a constant-table read is in the same cycle.
// - 256 bytes sit in internal RAM and 8192 or 4096 bytes in on-chip XRAM.
// - the bank select register answers at 0x84 on every SFR page.
module psbs_top (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // variant strap, static
    input wire logic small_xram,
    // special-function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire psbs_pkg::psbs_laddr_t exec_pc,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // instruction fetch
    input wire logic fetch_req,
    input wire psbs_pkg::psbs_laddr_t fetch_addr,
    output logic fetch_flash_rd,
    output psbs_pkg::psbs_paddr_t fetch_flash_addr,
    // constant-table read
    input wire logic movc_req,
    input wire psbs_pkg::psbs_laddr_t movc_addr,
    output logic const_flash_rd,
    output psbs_pkg::psbs_paddr_t const_flash_addr,
    // data move
    input wire logic movx_req,
    input wire logic movx_write,
    input wire logic flash_write_en,
    input wire psbs_pkg::psbs_laddr_t movx_addr,
    input wire logic [7:0] movx_wdata,
    output logic flash_wr,
    output psbs_pkg::psbs_paddr_t flash_wr_addr,
    output logic [7:0] flash_wr_data,
    output logic xram_rd,
    output logic xram_wr,
    output logic [psbs_pkg::PSBS_XRAM_W-1:0] xram_addr,
    output logic [7:0] xram_wdata,
    // direct internal RAM
    input wire logic iram_req,
    input wire logic iram_write,
    input wire logic [7:0] iram_addr_in,
    output logic iram_rd,
    output logic iram_wr,
    output logic [psbs_pkg::PSBS_IRAM_W-1:0] iram_addr
);
    import psbs_pkg::*;

    // ========================================================
    // bank select register state
    psbs_bank_t fetch_bank_field_r;
    psbs_bank_t constant_bank_field_r;
    logic [12:0] xram_mask_r;
    logic sfr_sel;
    logic code_in_bank0;
    logic movx_to_flash;
    psbs_laddr_t const_laddr;

    // translation carrier and mapper
    psbs_map_if map_c ();

    psbs_mapper u_mapper (
        .m (map_c.mapper)
    );

    // decode ignores any page selection
    assign sfr_sel = (sfr_addr == PSBS_SFR_ADDR);

    // writer runs from bank 0: lower half, or upper half with bank 0 fetched
    assign code_in_bank0 = (psbs_eff_bank(exec_pc, fetch_bank_field_r) == PSBS_BANK0);

    // a data-move write goes to flash only when flash writing is enabled
    assign movx_to_flash = movx_req && movx_write && flash_write_en;

    // constant path serves either the table read or the flash write
    assign const_laddr = movc_req ? movc_addr : movx_addr;

    // feed the mapper
    assign map_c.fetch_laddr = fetch_addr;
    assign map_c.const_laddr = const_laddr;
    assign map_c.fetch_bank = fetch_bank_field_r;
    assign map_c.const_bank = constant_bank_field_r;

    // ========================================================
    // fetch bank field, guarded by writer bank
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            fetch_bank_field_r <= PSBS_RESET_VAL[PSBS_FETCH_LSB +: PSBS_BANK_W];
        end else if (sfr_wr && sfr_sel && code_in_bank0) begin
            fetch_bank_field_r <= sfr_wdata[PSBS_FETCH_LSB +: PSBS_BANK_W];
        end
    end

    // constant bank field, writable from any bank
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            constant_bank_field_r <= PSBS_RESET_VAL[PSBS_CONST_LSB +: PSBS_BANK_W];
        end else if (sfr_wr && sfr_sel) begin
            constant_bank_field_r <= sfr_wdata[PSBS_CONST_LSB +: PSBS_BANK_W];
        end
    end

    // ========================================================
    // register read port, reserved bits return zero
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sfr_rdata <= 8'h00;
            sfr_hit <= 1'b0;
        end else begin
            sfr_hit <= (sfr_rd || sfr_wr) && sfr_sel;
            if (sfr_rd && sfr_sel) begin
                sfr_rdata <= 8'h00;
                sfr_rdata[PSBS_FETCH_LSB +: PSBS_BANK_W] <= fetch_bank_field_r;
                sfr_rdata[PSBS_CONST_LSB +: PSBS_BANK_W] <= constant_bank_field_r;
            end else begin
                sfr_rdata <= 8'h00;
            end
        end
    end

    // ========================================================
    // xram size mask, sampled from the strap on every clock after reset release
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            xram_mask_r <= PSBS_XRAM_MASK_BIG;
        end else begin
            xram_mask_r <= small_xram ? PSBS_XRAM_MASK_SMALL : PSBS_XRAM_MASK_BIG;
        end
    end

    // ========================================================
    // instruction fetch to flash
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            fetch_flash_rd <= 1'b0;
            fetch_flash_addr <= '0;
        end else begin
            fetch_flash_rd <= fetch_req;
            if (fetch_req) begin
                fetch_flash_addr <= map_c.fetch_paddr;
            end
        end
    end

    // constant-table read, always to flash
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            const_flash_rd <= 1'b0;
            const_flash_addr <= '0;
        end else begin
            const_flash_rd <= movc_req;
            if (movc_req) begin
                const_flash_addr <= map_c.const_paddr;
            end
        end
    end

    // flash erase or program by data-move write
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            flash_wr <= 1'b0;
            flash_wr_addr <= '0;
            flash_wr_data <= 8'h00;
        end else begin
            flash_wr <= movx_to_flash && !movc_req;
            if (movx_to_flash && !movc_req) begin
                flash_wr_addr <= map_c.const_paddr;
                flash_wr_data <= movx_wdata;
            end
        end
    end

    // ========================================================
    // data-move access to on-chip XRAM, addresses alias by size
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            xram_rd <= 1'b0;
            xram_wr <= 1'b0;
            xram_addr <= '0;
            xram_wdata <= 8'h00;
        end else begin
            xram_rd <= movx_req && !movx_write;
            xram_wr <= movx_req && movx_write && !flash_write_en;
            if (movx_req) begin
                xram_addr <= movx_addr[PSBS_XRAM_W-1:0] & xram_mask_r;
                xram_wdata <= movx_wdata;
            end
        end
    end

    // direct internal RAM, 256 bytes
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            iram_rd <= 1'b0;
            iram_wr <= 1'b0;
            iram_addr <= '0;
        end else begin
            iram_rd <= iram_req && !iram_write;
            iram_wr <= iram_req && iram_write;
            if (iram_req) begin
                iram_addr <= iram_addr_in;
            end
        end
    end

endmodule // psbs_top
`default_nettype wire

// File: sim/psbs_chk.sv
// checker: timing and mapping relations at the top ports
// assumes: bound to psbs_top, one clock, async active-high reset
`timescale 1ns/100ps
`default_nettype none
module psbs_chk (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // requests
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic fetch_req,
    input wire psbs_pkg::psbs_laddr_t fetch_addr,
    input wire logic movc_req,
    input wire psbs_pkg::psbs_laddr_t movc_addr,
    input wire logic movx_req,
    input wire logic movx_write,
    input wire logic flash_write_en,
    // answers
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic fetch_flash_rd,
    input wire psbs_pkg::psbs_paddr_t fetch_flash_addr,
    input wire logic const_flash_rd,
    input wire psbs_pkg::psbs_paddr_t const_flash_addr,
    input wire logic flash_wr,
    input wire logic xram_rd,
    input wire logic xram_wr
);
    import psbs_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // register access at its own address
    sequence s_sfr_req;
        (sfr_wr || sfr_rd) && sfr_addr == PSBS_SFR_ADDR;
    endsequence
    // relations between requests and answers
    hit_follows_a: assert property (s_sfr_req |=> sfr_hit) else $error("no hit");
    hit_cause_a: assert property (sfr_hit |-> $past(sfr_addr) == PSBS_SFR_ADDR)
        else $error("stray hit");
    rsvd_zero_a: assert property (sfr_rdata[7:6] == 2'h0 && sfr_rdata[3:2] == 2'h0)
        else $error("reserved set");
    low_fetch_a: assert property (fetch_req && !fetch_addr[15] |=> fetch_flash_rd
        && fetch_flash_addr == {2'h0, 15'($past(fetch_addr))}) else $error("low fetch");
    fetch_ofs_a: assert property (fetch_req |=> fetch_flash_addr[14:0] == 15'($past(fetch_addr)))
        else $error("fetch offset");
    low_const_a: assert property (movc_req && !movc_addr[15] |=> const_flash_rd
        && const_flash_addr[16:15] == 2'h0) else $error("low const");
    movc_flash_a: assert property (movc_req && !movx_req |=> const_flash_rd && !xram_rd && !xram_wr)
        else $error("movc path");
    xram_write_a: assert property (movx_req && movx_write && !flash_write_en |=> xram_wr && !flash_wr)
        else $error("xram write");
    flash_write_a: assert property (movx_req && movx_write && flash_write_en && !movc_req
        |=> flash_wr && !xram_wr) else $error("flash write");
endmodule // psbs_chk
bind psbs_top psbs_chk chk (.clock, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .fetch_req, .fetch_addr,
    .movc_req, .movc_addr, .movx_req, .movx_write, .flash_write_en, .sfr_rdata, .sfr_hit,
    .fetch_flash_rd, .fetch_flash_addr, .const_flash_rd, .const_flash_addr, .flash_wr,
    .xram_rd, .xram_wr);
`default_nettype wire

// File: sim/psbs_core_model.sv
// core model: issues register, fetch, constant, data and ram requests
// assumes: requests change on the falling edge of clock
`timescale 1ns/100ps
`default_nettype none
module psbs_core_model (
    // clock
    input wire logic clock,
    // register requests
    output logic small_xram,
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic [7:0] sfr_wdata,
    output psbs_pkg::psbs_laddr_t exec_pc,
    // memory requests
    output logic fetch_req,
    output psbs_pkg::psbs_laddr_t fetch_addr,
    output logic movc_req,
    output psbs_pkg::psbs_laddr_t movc_addr,
    output logic movx_req,
    output logic movx_write,
    output logic flash_write_en,
    output psbs_pkg::psbs_laddr_t movx_addr,
    output logic [7:0] movx_wdata,
    output logic iram_req,
    output logic iram_write,
    output logic [7:0] iram_addr_in
);
    import psbs_pkg::*;
    // idle core at time zero
    initial begin
        {small_xram, sfr_addr, sfr_wr, sfr_rd, sfr_wdata, exec_pc, fetch_req, fetch_addr} = '0;
        {movc_req, movc_addr, movx_req, movx_write, flash_write_en, movx_addr} = '0;
        {movx_wdata, iram_req, iram_write, iram_addr_in} = '0;
    end
    // one register access, stale data inverted afterwards
    task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d,
        input psbs_laddr_t pc);
        @(negedge clock);
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, exec_pc} = {w, !w, a, d, pc};
        @(negedge clock);
        {sfr_wr, sfr_rd, sfr_wdata} = {2'h0, ~d};
    endtask
    // variant strap change, off the sampling edge
    task automatic strap(input logic s);
        @(negedge clock);
        small_xram = s;
    endtask
    // one request of kind k: 0 fetch, 1 movc, 2 movx, 3 iram
    task automatic mem(input int k, input psbs_laddr_t a, input logic w, input logic e,
        input logic [7:0] d);
        @(negedge clock);
        {fetch_addr, movc_addr, movx_addr, iram_addr_in} = {a, a, a, a[7:0]};
        {movx_write, iram_write, flash_write_en, movx_wdata} = {w, w, e, d};
        {fetch_req, movc_req, movx_req, iram_req} = 4'h8 >> k;
        @(negedge clock);
        {fetch_req, movc_req, movx_req, iram_req, fetch_addr, movc_addr} = {4'h0, ~a, ~a};
    endtask
endmodule // psbs_core_model
`default_nettype wire

// File: sim/psbs_top_tb.sv
// testbench: register, bank steering and memory routing scenarios
// assumes: core model drives all requests, checker bound to the top
`timescale 1ns/100ps
`default_nettype none
module psbs_top_tb;
    import psbs_pkg::*;
    logic clock, reset, small_xram, sfr_wr, sfr_rd, fetch_req, movc_req, movx_req, movx_write;
    logic flash_write_en, iram_req, iram_write, sfr_hit, fetch_flash_rd, const_flash_rd;
    logic flash_wr, xram_rd, xram_wr, iram_rd, iram_wr;
    logic [7:0] sfr_addr, sfr_wdata, movx_wdata, iram_addr_in, sfr_rdata, flash_wr_data;
    logic [7:0] xram_wdata, iram_addr;
    logic [12:0] xram_addr;
    psbs_laddr_t exec_pc, fetch_addr, movc_addr, movx_addr;
    psbs_paddr_t fetch_flash_addr, const_flash_addr, flash_wr_addr;
    int miscompares = 0;
    int checks_done = 0;
    psbs_core_model core (.clock, .small_xram, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
        .exec_pc, .fetch_req, .fetch_addr, .movc_req, .movc_addr, .movx_req, .movx_write,
        .flash_write_en, .movx_addr, .movx_wdata, .iram_req, .iram_write, .iram_addr_in);
    psbs_top dut (.clock, .reset, .small_xram, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
        .exec_pc, .sfr_rdata, .sfr_hit, .fetch_req, .fetch_addr, .fetch_flash_rd,
        .fetch_flash_addr, .movc_req, .movc_addr, .const_flash_rd, .const_flash_addr,
        .movx_req, .movx_write, .flash_write_en, .movx_addr, .movx_wdata, .flash_wr,
        .flash_wr_addr, .flash_wr_data, .xram_rd, .xram_wr, .xram_addr, .xram_wdata,
        .iram_req, .iram_write, .iram_addr_in, .iram_rd, .iram_wr, .iram_addr);
    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // compare and count
    task automatic ck(input string n, input logic [16:0] e, input logic [16:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // read the bank select byte
    task automatic rd(output logic [7:0] v);
        core.sfr(1'b0, 8'h84, 8'h00, 16'h0000);
        v = sfr_rdata;
    endtask
    // values straight out of reset
    task automatic t_reset();
        logic [7:0] v;
        rd(v); // read before any write
        ck("reset value", 17'h00011, {9'h0, v});
        core.mem(0, 16'h9234, 1'b0, 1'b0, 8'h00);
        ck("reset fetch", 17'h09234, fetch_flash_addr);
        core.mem(1, 16'hF00D, 1'b0, 1'b0, 8'h00);
        ck("reset const", 17'h0F00D, const_flash_addr);
    endtask
    // every bank code in both fields, reserved bits written high
    task automatic t_banks();
        logic [7:0] v;
        for (int b = 0; b < 4; b++) begin
            core.sfr(1'b1, 8'h84, {2'h3, 2'(3 - b), 2'h3, 2'(b)}, 16'h0100); // full part
            rd(v);
            ck("bank reg", {11'h0, 2'(3 - b), 2'h0, 2'(b)}, {9'h0, v});
            core.mem(0, 16'hC001, 1'b0, 1'b0, 8'h00);
            ck("fetch bank", {2'(b), 15'h4001}, fetch_flash_addr);
            core.mem(1, 16'hFFFF, 1'b0, 1'b0, 8'h00);
            ck("const bank", {2'(3 - b), 15'h7FFF}, const_flash_addr);
            core.mem(0, 16'h7FFF, 1'b0, 1'b0, 8'h00);
            ck("low fetch", 17'h07FFF, fetch_flash_addr);
        end
    endtask
    // fetch field locked outside bank 0, other address ignored
    task automatic t_lock();
        logic [7:0] v;
        core.sfr(1'b1, 8'h84, 8'h00, 16'h0100);
        core.sfr(1'b1, 8'h84, 8'h03, 16'h9000);
        rd(v);
        ck("upper bank 0 writer", 17'h00003, {9'h0, v});
        core.sfr(1'b1, 8'h84, 8'h02, 16'h0100);
        core.sfr(1'b1, 8'h84, 8'h31, 16'h8100);
        rd(v);
        ck("locked fetch", 17'h00032, {9'h0, v});
        core.sfr(1'b1, 8'h84, 8'h11, 16'h0010);
        core.sfr(1'b1, 8'h85, 8'h00, 16'h0010);
        ck("other address", 17'h0, {16'h0, sfr_hit});
        rd(v);
        ck("unlocked", 17'h00011, {9'h0, v});
    endtask
    // register back to its reset value after a mid-run reset
    task automatic t_rereset();
        logic [7:0] v;
        core.sfr(1'b1, 8'h84, 8'h32, 16'h0100);
        reset = 1'b1;
        repeat (2) @(negedge clock);
        reset = 1'b0;
        rd(v);
        ck("reset again", 17'h00011, {9'h0, v});
    endtask
    // data moves to xram or flash, small variant, internal ram
    task automatic t_movx();
        core.mem(2, 16'hABCD, 1'b1, 1'b0, 8'h5A);
        ck("xram write", 17'h10BCD, {xram_wr, 3'h0, xram_addr});
        ck("xram data", 17'h0005A, {9'h0, xram_wdata});
        core.mem(2, 16'hABCD, 1'b1, 1'b1, 8'hA5);
        ck("flash write", 17'h0ABCD, flash_wr_addr);
        ck("flash only", 17'h1, {16'h0, flash_wr & ~xram_wr});
        ck("flash data", 17'h000A5, {9'h0, flash_wr_data});
        core.mem(2, 16'h1FFF, 1'b0, 1'b1, 8'h00);
        ck("xram read", 17'h11FFF, {xram_rd, 3'h0, xram_addr});
        core.strap(1'b1); // register left at 0x11 on the small part
        core.mem(2, 16'h1FFF, 1'b0, 1'b0, 8'h00);
        ck("small xram", 17'h10FFF, {xram_rd, 3'h0, xram_addr});
        core.mem(3, 16'h00C3, 1'b1, 1'b0, 8'h00);
        ck("iram write", 17'h100C3, {iram_wr, iram_rd, 7'h0, iram_addr});
    endtask
    // reset then scenarios
    initial begin
        reset = 1'b1;
        repeat (20) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        t_reset();
        t_banks();
        t_lock();
        t_rereset();
        t_movx();
        report_and_stop();
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        report_and_stop();
    end
endmodule // psbs_top_tb
`default_nettype wire
